// File: logic/light_sensor_level_readout.sv
// Purpose: dark-level comparator and sensor result registers
// Assumes: host register port on mclk; sensor inputs are asynchronous
// Notes: reads are combinational; results latch on each refresh tick
//
// Contract
// R01: in dark, leave for office when input exceeds threshold plus hysteresis.
// R02: hysteresis code is 0.54 uA per step, zero means none.
// R03: sensor one result bits 7..0 read at low-byte register.
// R04: bits 12..8 read in high-byte bits 4..0, bits 7..5 zero.
// R05: results refresh every 80 ms only while sensing is enabled.
// R06: result registers are read-only; host writes have no effect.
// R07: sensor two result split over its own low and high registers.
// R08: enter dark when input falls below the dark threshold.
`include "light_sensor_map.svh"
`default_nettype none
module light_sensor_level_readout
  import light_sensor_pkg::*;
#(
  // 80 ms is far too long to simulate; a bench may shorten the period
  parameter logic [19:0] REFRESH_PERIOD = 20'(`REFRESH_CYCLES)
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic sense_enable,
  input wire logic [12:0] sensor1_raw,
  input wire logic [12:0] sensor2_raw,
  input wire logic [7:0] comparator_sense_input,
  output logic dark_level,
  output result_pair_t results
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // raw words may change mid-sample; a real front end should hold
  // them steady around the tick, two stages only guard metastability
  logic [12:0] s1_meta_q;
  logic [12:0] s1_sync_q;
  logic [12:0] s2_meta_q;
  logic [12:0] s2_sync_q;
  logic [7:0] cmp_meta_q;
  logic [7:0] cmp_sync_q;
  logic en_meta_q;
  logic en_sync_q;
  always_ff @(posedge mclk)
  begin
    s1_meta_q <= sensor1_raw;
    s1_sync_q <= s1_meta_q;
    s2_meta_q <= sensor2_raw;
    s2_sync_q <= s2_meta_q;
    cmp_meta_q <= comparator_sense_input;
    cmp_sync_q <= cmp_meta_q;
    en_meta_q <= sense_enable;
    en_sync_q <= en_meta_q;
  end
  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] dark_threshold_q;
  logic [7:0] dark_hysteresis_q;
  wire wr_thr = reg_req.wr && (reg_req.addr == `ADDR_DARK_THRESHOLD);
  wire wr_hys = reg_req.wr && (reg_req.addr == `ADDR_DARK_HYSTERESIS);
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dark_threshold_q <= `RST_BYTE;
      dark_hysteresis_q <= `RST_BYTE;
    end
    else
    begin
      if (wr_thr)
        dark_threshold_q <= reg_req.wdata;
      if (wr_hys)
        dark_hysteresis_q <= reg_req.wdata; // R02
    end
  end
  // ****************************************************************
  // dark-level comparator
  // ****************************************************************
  // hysteresis and threshold share the 0.54 uA step, so code units add
  // directly; the sum is 9 bits so a large setting never wraps
  level_t level_q;
  level_t level_d;
  wire [`SUM_W-1:0] exit_point =
    {1'b0, dark_threshold_q} + {1'b0, dark_hysteresis_q}; // R02
  wire below_thr = cmp_sync_q < dark_threshold_q; // R08
  wire above_exit = {1'b0, cmp_sync_q} > exit_point; // R01
  always_comb
  begin
    level_d = level_q;
    case (level_q)
      LVL_OFFICE:
        if (below_thr)
          level_d = LVL_DARK; // R08
      LVL_DARK:
        if (above_exit)
          level_d = LVL_OFFICE; // R01
      default:
        level_d = LVL_OFFICE;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
      level_q <= LVL_OFFICE;
    else
      level_q <= level_d;
  end
  assign dark_level = (level_q == LVL_DARK);
  // ****************************************************************
  // result capture
  // ****************************************************************
  logic refresh_tick;
  refresh_timer #(.PERIOD(REFRESH_PERIOD)) u_timer
  (
    .mclk(mclk),
    .srst(srst),
    .enable(en_sync_q),
    .tick(refresh_tick)
  );
  result_pair_t results_q;
  // only reset and the tick load results; the host port has no path here
  always_ff @(posedge mclk)
  begin
    if (srst)
      results_q <= '{sensor1: `RST_RESULT, sensor2: `RST_RESULT};
    else if (refresh_tick)
      results_q <= '{sensor1: s1_sync_q, sensor2: s2_sync_q}; // R05 R06
  end
  assign results = results_q;
  // ****************************************************************
  // read decode
  // ****************************************************************
  wire hit_thr = reg_req.addr == `ADDR_DARK_THRESHOLD;
  wire hit_hys = reg_req.addr == `ADDR_DARK_HYSTERESIS;
  wire hit_s1l = reg_req.addr == `ADDR_SENSOR1_LOW;
  wire hit_s1h = reg_req.addr == `ADDR_SENSOR1_HIGH;
  wire hit_s2l = reg_req.addr == `ADDR_SENSOR2_LOW;
  wire hit_s2h = reg_req.addr == `ADDR_SENSOR2_HIGH;
  wire [7:0] sensor1_result_low_bits = results_q.sensor1[7:0]; // R03
  wire [7:0] sensor1_result_high_bits =
    {`HIGH_PAD, results_q.sensor1[12:8]}; // R04
  wire [7:0] sensor2_result_low_bits = results_q.sensor2[7:0]; // R07
  wire [7:0] sensor2_result_high_bits =
    {`HIGH_PAD, results_q.sensor2[12:8]}; // R04 R07
  assign reg_hit = reg_req.rd &&
    (hit_thr || hit_hys || hit_s1l || hit_s1h || hit_s2l || hit_s2h);
  assign reg_rdata =
    !reg_req.rd ? `RST_BYTE :
    hit_thr ? dark_threshold_q :
    hit_hys ? dark_hysteresis_q :
    hit_s1l ? sensor1_result_low_bits :
    hit_s1h ? sensor1_result_high_bits :
    hit_s2l ? sensor2_result_low_bits :
    hit_s2h ? sensor2_result_high_bits :
    `RST_BYTE;
endmodule : light_sensor_level_readout
`default_nettype wire

// File: logic/refresh_timer.sv
// Purpose: periodic refresh strobe while sensing is enabled
// Assumes: mclk at the rate in the map header
// Notes: counter restarts whenever sensing is disabled
`include "light_sensor_map.svh"
`default_nettype none
module refresh_timer
#(
  parameter logic [19:0] PERIOD = 20'(`REFRESH_CYCLES)
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable,
  output logic tick
);
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] cnt_d;
  wire at_end = (cnt_q == PERIOD - `CNT_ONE);
  assign cnt_d = (!enable || at_end) ? `CNT_ZERO : cnt_q + `CNT_ONE;
  // one-cycle enable pulse, only while sensing is on
  assign tick = enable && at_end;
  always_ff @(posedge mclk)
  begin
    if (srst)
      cnt_q <= `CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end
endmodule : refresh_timer
`default_nettype wire

// File: pkg/light_sensor_map.svh
// Purpose: register offsets, field positions, reset values, timing
// Assumes: 10 MHz mclk
// Notes: included by bare name
`ifndef LIGHT_SENSOR_MAP_SVH
`define LIGHT_SENSOR_MAP_SVH
`define ADDR_DARK_THRESHOLD 8'h1F
`define ADDR_DARK_HYSTERESIS 8'h20
`define ADDR_SENSOR1_LOW 8'h21
`define ADDR_SENSOR1_HIGH 8'h22
`define ADDR_SENSOR2_LOW 8'h23
`define ADDR_SENSOR2_HIGH 8'h24
`define RST_BYTE 8'h00
`define RST_RESULT 13'h0000
`define HIGH_PAD 3'h0
`define CLK_HZ 10000000
`define REFRESH_MS 80
`define REFRESH_CYCLES ((`CLK_HZ / 1000) * `REFRESH_MS)
`define CNT_W 20
`define CNT_ZERO 20'h00000
`define CNT_ONE 20'h00001
`define SUM_W 9
`endif

// File: pkg/light_sensor_pkg.sv
// Purpose: shared types for the light sensor readout
// Assumes: nothing
// Notes: constants live in light_sensor_map.svh
`default_nettype none
package light_sensor_pkg;
  typedef enum logic [1:0]
  {
    LVL_OFFICE = 2'h0,
    LVL_DARK = 2'h1
  } level_t;
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed
  {
    logic [12:0] sensor1;
    logic [12:0] sensor2;
  } result_pair_t;
endpackage : light_sensor_pkg
`default_nettype wire

// File: tb/host_model.sv
// Purpose: host side of the register port
// Assumes: one request at a time, sampled on rising mclk
// Notes: released address is inverted, data is ~d after a write and A5 after a read, never left stale
`default_nettype none
module host_model
  import light_sensor_pkg::*;
(
  input wire logic mclk,
  output var reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_req = '0;
  task write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write
  task read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(posedge mclk);
    d = reg_rdata;
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
  endtask : read
endmodule : host_model
`default_nettype wire

// File: tb/light_sensor_level_readout_test.sv
// Purpose: self-checking bench for the readout
// Assumes: refresh period shortened to 16 cycles on the instance
// Notes: sensing is enabled late, after the reset-value checks
`default_nettype none
module light_sensor_level_readout_test
  import light_sensor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic sense_enable = 1'b0;
  logic [12:0] s1 = 13'h1ABC;
  logic [12:0] s2 = 13'h0F0F;
  logic [7:0] cmp = 8'h00;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic dark_level;
  result_pair_t res_w;
  logic [7:0] rd_v;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #50 mclk = ~mclk;
  light_sensor_level_readout #(.REFRESH_PERIOD(20'h00010))
    i_light_sensor_level_readout (.mclk, .srst,
    .reg_req, .reg_rdata, .reg_hit, .sense_enable, .sensor1_raw(s1),
    .sensor2_raw(s2), .comparator_sense_input(cmp), .dark_level,
    .results(res_w));
  host_model i_host_model (.mclk, .reg_req, .reg_rdata);
  task chk(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task rchk(input logic [7:0] a, input logic [12:0] exp);
    i_host_model.read(a, rd_v);
    chk({5'h00, rd_v}, exp);
  endtask : rchk
  task pchk(input logic [7:0] a, input logic [12:0] v);
    rchk(a, {5'h00, v[7:0]});
    rchk(a + 8'h01, {8'h00, v[12:8]});
  endtask : pchk
  // a disabled window with changed inputs must not reach the registers
  task t_refresh;
    sense_enable <= 1'b1;
    repeat (24) @(posedge mclk);
    sense_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    s1 <= 13'h0AAA;
    s2 <= 13'h10F0;
    repeat (40) @(posedge mclk);
    for (int i = 0; i < 4; i++) i_host_model.write(8'h21 + 8'(i), 8'hFF);
    pchk(8'h21, 13'h1555);
    pchk(8'h23, 13'h0F0F);
    sense_enable <= 1'b1;
    repeat (24) @(posedge mclk);
    pchk(8'h21, 13'h0AAA);
    pchk(8'h23, 13'h10F0);
  endtask : t_refresh
  task t_ro;
    s1 <= 13'h1555;
    for (int i = 0; i < 4; i++) i_host_model.write(8'h21 + 8'(i), 8'hFF);
    for (int i = 0; i < 4; i++) rchk(8'h21 + 8'(i), 13'h0000);
    chk(res_w.sensor1, 13'h0000);
  endtask : t_ro
  task t_hys;
    i_host_model.write(8'h20, 8'hFF);
    rchk(8'h20, 13'h00FF);
    rchk(8'h30, 13'h0000);
  endtask : t_hys
  // boundaries: equal to threshold or exit point must not switch
  task t_dark;
    cmp <= 8'h40;
    i_host_model.write(8'h1F, 8'h40);
    i_host_model.write(8'h20, 8'h10);
    repeat (6) @(posedge mclk);
    chk({12'h000, dark_level}, 13'h0000);
    cmp <= 8'h3F;
    repeat (6) @(posedge mclk);
    chk({12'h000, dark_level}, 13'h0001);
    cmp <= 8'h50;
    repeat (6) @(posedge mclk);
    chk({12'h000, dark_level}, 13'h0001);
    cmp <= 8'h51;
    repeat (6) @(posedge mclk);
    chk({12'h000, dark_level}, 13'h0000);
  endtask : t_dark
  task results;
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    t_ro();
    t_hys();
    t_dark();
    t_refresh();
    results();
  end
endmodule : light_sensor_level_readout_test
`default_nettype wire

// File: tb/readout_props.sv
// Purpose: port checks for the light sensor readout
// Assumes: three-edge comparator latency, host writes on the port
// Notes: threshold and hysteresis are shadowed from host writes
`default_nettype none
module readout_props
  import light_sensor_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic sense_enable,
  input wire logic [7:0] comparator_sense_input,
  input wire logic dark_level,
  input wire result_pair_t results
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] thr_q;
  logic [7:0] hys_q;
  wire logic rd = reg_req.rd;
  wire logic [7:0] a = reg_req.addr;
  // 9-bit sum so a large hysteresis cannot wrap the exit point
  wire logic [8:0] top = {1'b0, thr_q} + {1'b0, hys_q};
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      thr_q <= 8'h00;
      hys_q <= 8'h00;
    end
    else if (reg_req.wr && a == 8'h1F)
      thr_q <= reg_req.wdata;
    else if (reg_req.wr && a == 8'h20)
      hys_q <= reg_req.wdata;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence below_s;
    ({1'b0, comparator_sense_input} < {1'b0, thr_q})[*4];
  endsequence
  sequence above_s; ({1'b0, comparator_sense_input} > top)[*4]; endsequence
  a_low_one: assert property (rd && a == 8'h21 |->
    reg_rdata == results.sensor1[7:0]) else $error("sensor one low byte");
  a_high_one: assert property (rd && a == 8'h22 |->
    reg_rdata == {3'h0, results.sensor1[12:8]}) else $error("one high byte");
  a_low_two: assert property (rd && a == 8'h23 |->
    reg_rdata == results.sensor2[7:0]) else $error("sensor two low byte");
  a_high_two: assert property (rd && a == 8'h24 |->
    reg_rdata == {3'h0, results.sensor2[12:8]}) else $error("two high byte");
  a_results_hold: assert property (!sense_enable[*4] |=>
    $stable(results)) else $error("results moved while disabled");
  a_enter_dark: assert property (below_s |=> dark_level)
    else $error("dark level not entered");
  a_leave_dark: assert property (above_s |=> !dark_level)
    else $error("dark level not left");
  a_hit_mapped: assert property (rd && a >= 8'h1F && a <= 8'h24 |->
    reg_hit) else $error("mapped read not hit");
  a_hit_unmapped: assert property (rd && (a < 8'h1F || a > 8'h24) |->
    !reg_hit && reg_rdata == 8'h00) else $error("unmapped read answered");
  a_hys_read: assert property (rd && a == 8'h20 |->
    reg_rdata == hys_q) else $error("hysteresis read back wrong");
  a_thr_read: assert property (rd && a == 8'h1F |->
    reg_rdata == thr_q) else $error("threshold read back wrong");
endmodule : readout_props
bind light_sensor_level_readout readout_props i_readout_props (.mclk, .srst,
  .reg_req, .reg_rdata, .reg_hit, .sense_enable, .comparator_sense_input,
  .dark_level, .results);
`default_nettype wire
